// ==== rtl/utmi_sie_pkg.sv ====
package utmi_sie_pkg;
	localparam int unsigned DATA_W = 16;
	// line state encodings
	localparam logic [1:0] LINE_SE0 = 2'h0;
	localparam logic [1:0] LINE_J   = 2'h1;
	localparam logic [1:0] LINE_K   = 2'h2;
	localparam logic [1:0] LINE_SE1 = 2'h3;
	// operating mode encodings
	localparam logic [1:0] OPMODE_NORMAL   = 2'h0;
	localparam logic [1:0] OPMODE_NODRIVE  = 2'h1;
	localparam logic [1:0] OPMODE_RAW      = 2'h2;
	localparam logic [1:0] OPMODE_RESERVED = 2'h3;
	// inter-packet gap, in word clocks; plain default
	localparam int unsigned IPG_CYCLES = 8;
	// idle cycles of line state required before a packet
	localparam int unsigned IDLE_CYCLES = 2;
	// reset value of the operating mode
	localparam logic [1:0] OPMODE_RESET = 2'h0;
	typedef enum logic [1:0] {
		TX_WAIT = 2'b00,
		TX_DATA = 2'b01,
		TX_GAP  = 2'b10
	} tx_state_t;
endpackage

// ==== rtl/skid_buffer.sv ====
// two-entry buffer; a full buffer drops in_ready and does not take a word offered then
module skid_buffer #(
	parameter int unsigned WIDTH = 16
) (
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             reset,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] mem_q [2];
	logic             wr_q;
	logic             rd_q;
	logic [1:0]       count_q;
	logic             push;
	logic             pop;

	assign in_ready  = (count_q != 2'h2);
	assign out_valid = (count_q != 2'h0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_q[rd_q];

	always_ff @(posedge core_clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			wr_q    <= 1'b0;
			rd_q    <= 1'b0;
			count_q <= 2'h0;
		end else begin
			if (push) begin
				wr_q <= ~wr_q;
			end
			if (pop) begin
				rd_q <= ~rd_q;
			end
			count_q <= count_q + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule

// ==== rtl/utmi_sie.sv ====
module utmi_sie #(
	parameter int unsigned DATA_W      = utmi_sie_pkg::DATA_W,
	parameter int unsigned IPG_CYCLES  = utmi_sie_pkg::IPG_CYCLES,
	parameter int unsigned IDLE_CYCLES = utmi_sie_pkg::IDLE_CYCLES
) (
	// clock and reset
	input  wire logic              core_clk,
	input  wire logic              reset,
	// user transmit stream; last marks the final word
	input  wire logic              tx_in_valid,
	output logic                   tx_in_ready,
	input  wire logic [DATA_W-1:0] tx_in_data,
	input  wire logic              tx_in_last,
	// user receive stream
	output logic                   rx_out_valid,
	input  wire logic              rx_out_ready,
	output logic      [DATA_W-1:0] rx_out_data,
	output logic                   rx_out_last,
	output logic                   rx_out_error,
	// user mode control
	input  wire logic [1:0]        mode_request,
	// transceiver pins
	output logic                   transmit_valid,
	input  wire logic              transmit_ready,
	output logic      [DATA_W-1:0] data_out,
	output logic                   data_oe,
	input  wire logic [DATA_W-1:0] data_in,
	input  wire logic              receive_active,
	input  wire logic              receive_valid,
	input  wire logic              receive_error,
	input  wire logic [1:0]        line_state,
	output logic                   operating_mode_select_hi,
	output logic                   operating_mode_select_lo
);
	utmi_sie_pkg::tx_state_t state_q;
	logic [DATA_W:0]  pend_q;
	logic             pend_valid_q;
	logic [7:0]       gap_q;
	logic [3:0]       idle_q;
	logic [1:0]       mode_q;
	logic             bus_idle;
	logic             take;
	logic             accept;
	logic             rx_word;
	logic             rx_end;
	logic             act_q;
	logic             err_q;
	logic             buf_in_ready;
	logic [DATA_W+1:0] buf_out;

	// j is idle on the line for full speed
	assign bus_idle = (line_state == utmi_sie_pkg::LINE_J) ||
		(line_state == utmi_sie_pkg::LINE_SE0);
	assign accept   = transmit_valid && transmit_ready;
	assign take     = tx_in_valid && tx_in_ready;
	// a new word is taken only when the pending one has gone
	assign tx_in_ready = (state_q != utmi_sie_pkg::TX_GAP) &&
		(!pend_valid_q || accept) &&
		!(pend_valid_q && pend_q[DATA_W] && !accept);
	assign data_out = pend_q[DATA_W-1:0];
	assign data_oe  = transmit_valid;
	assign operating_mode_select_hi = mode_q[1];
	assign operating_mode_select_lo = mode_q[0];

	// reserved mode code is never driven out
	always_ff @(posedge core_clk) begin
		if (reset) begin
			mode_q <= utmi_sie_pkg::OPMODE_RESET;
		end else if (mode_request != utmi_sie_pkg::OPMODE_RESERVED) begin
			mode_q <= mode_request;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset || !bus_idle || receive_active) begin
			idle_q <= 4'h0;
		end else if (idle_q != 4'hf) begin
			idle_q <= idle_q + 4'h1;
		end
	end

	// pending word register; holds still until accepted
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pend_q       <= '0;
			pend_valid_q <= 1'b0;
		end else if (take) begin
			pend_q       <= {tx_in_last, tx_in_data};
			pend_valid_q <= 1'b1;
		end else if (accept) begin
			pend_valid_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_q        <= utmi_sie_pkg::TX_WAIT;
			transmit_valid <= 1'b0;
			gap_q          <= 8'h00;
		end else begin
			case (state_q)
				utmi_sie_pkg::TX_WAIT: begin
					// pid is already on the bus when valid rises
					if (pend_valid_q && idle_q >= 4'(IDLE_CYCLES) &&
						mode_q != utmi_sie_pkg::OPMODE_NODRIVE) begin
						transmit_valid <= 1'b1;
						state_q        <= utmi_sie_pkg::TX_DATA;
					end
				end
				utmi_sie_pkg::TX_DATA: begin
					if (accept && pend_q[DATA_W]) begin
						transmit_valid <= 1'b0;
						gap_q          <= 8'(IPG_CYCLES);
						state_q        <= utmi_sie_pkg::TX_GAP;
					end
				end
				utmi_sie_pkg::TX_GAP: begin
					// transmit_ready is not looked at here
					if (gap_q != 8'h00) begin
						gap_q <= gap_q - 8'h01;
					end else begin
						state_q <= utmi_sie_pkg::TX_WAIT;
					end
				end
				default: begin
					state_q        <= utmi_sie_pkg::TX_WAIT;
					transmit_valid <= 1'b0;
				end
			endcase
		end
	end

	// receive side: capture each valid word without error; drop all while sending or in the gap
	assign rx_word = receive_active && receive_valid && !receive_error &&
		(state_q == utmi_sie_pkg::TX_WAIT) && !transmit_valid;
	assign rx_end  = act_q && !receive_active && (state_q == utmi_sie_pkg::TX_WAIT);

	always_ff @(posedge core_clk) begin
		if (reset) begin
			act_q <= 1'b0;
			err_q <= 1'b0;
		end else begin
			act_q <= receive_active;
			if (!receive_active) begin
				err_q <= 1'b0;
			end else if (receive_error) begin
				err_q <= 1'b1;
			end
		end
	end

	// end marker travels as a zero-data word with last set; a full buffer
	// would drop words since the transceiver cannot be stalled
	skid_buffer #(
		.WIDTH(DATA_W + 2)
	) u_rx_buf (
		.core_clk (core_clk),
		.reset    (reset),
		.in_valid (rx_word || rx_end),
		.in_ready (buf_in_ready),
		.in_data  ({rx_end, err_q, rx_end ? {DATA_W{1'b0}} : data_in}),
		.out_valid(rx_out_valid),
		.out_ready(rx_out_ready),
		.out_data (buf_out)
	);

	assign rx_out_data  = buf_out[DATA_W-1:0];
	assign rx_out_error = buf_out[DATA_W];
	assign rx_out_last  = buf_out[DATA_W+1];

	sequence valid_rise_s;
		!transmit_valid ##1 transmit_valid;
	endsequence

	tx_hold_a: assert property (@(posedge core_clk) disable iff (reset)
		transmit_valid && !transmit_ready |=> $stable(data_out))
		else $error("data changed while ready low");
	tx_start_idle_a: assert property (@(posedge core_clk) disable iff (reset)
		valid_rise_s |-> $past(idle_q) >= 4'(IDLE_CYCLES))
		else $error("valid raised without idle bus");
	tx_pid_a: assert property (@(posedge core_clk) disable iff (reset)
		valid_rise_s |-> pend_valid_q)
		else $error("no word on bus at valid rise");
	tx_gap_a: assert property (@(posedge core_clk) disable iff (reset)
		$fell(transmit_valid) |-> !transmit_valid [*8])
		else $error("inter packet gap too short");
	tx_end_a: assert property (@(posedge core_clk) disable iff (reset)
		transmit_valid && accept && pend_q[DATA_W] |=> !transmit_valid)
		else $error("valid did not drop after last word");
	rx_drop_tx_a: assert property (@(posedge core_clk) disable iff (reset)
		transmit_valid |-> !rx_word)
		else $error("receive word kept while sending");
	mode_legal_a: assert property (@(posedge core_clk) disable iff (reset)
		mode_q != utmi_sie_pkg::OPMODE_RESERVED)
		else $error("reserved mode driven");
	rx_capture_a: assert property (@(posedge core_clk) disable iff (reset)
		rx_word |=> ##[0:2] rx_out_valid)
		else $error("captured word not offered");
	// an empty pending register while sending would resend a stale word
	tx_underrun_a: assert property (@(posedge core_clk) disable iff (reset)
		transmit_valid |-> pend_valid_q)
		else $error("sending without a pending word");
	// a full buffer loses the word: the transceiver cannot be held off
	rx_room_a: assert property (@(posedge core_clk) disable iff (reset)
		(rx_word || rx_end) |-> buf_in_ready)
		else $error("receive word lost to a full buffer");
endmodule

// ==== dv/utmi_xcvr_model.sv ====
module utmi_xcvr_model (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        reset,
	// transmit pins
	input  wire logic        transmit_valid,
	output logic             transmit_ready,
	input  wire logic [15:0] data_out,
	// receive pins
	output logic [15:0]      data_in,
	output logic             receive_active,
	output logic             receive_valid,
	output logic             receive_error,
	output logic [1:0]       line_state,
	// pacing from the bench
	input  wire logic        slow
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] tx_log[$];
	logic [15:0] prev_q;
	logic        wait_q;
	logic        hold_bad;
	initial begin
		line_state = utmi_sie_pkg::LINE_J;
		{receive_active, receive_valid, receive_error} = 3'h0;
		data_in = 16'h0000;
	end
	// slow mode answers every other cycle so the sender must hold its word
	always_ff @(posedge core_clk) begin
		if (reset) begin
			transmit_ready <= 1'b0;
		end else begin
			// ready one clock after valid rises stands for the start of sync
			transmit_ready <= transmit_valid && !(slow && transmit_ready);
		end
	end
	always @(posedge core_clk) begin
		if (!reset && transmit_valid && transmit_ready) tx_log.push_back(data_out);
	end
	// flags a word that changed while still waiting for ready
	always_ff @(posedge core_clk) begin
		wait_q <= !reset && transmit_valid && !transmit_ready;
		prev_q <= data_out;
		if (reset) hold_bad <= 1'b0;
		else if (wait_q && transmit_valid && data_out !== prev_q) hold_bad <= 1'b1;
	end
	// words pass undecoded, one clock each, a byte time apart
	// bad flags the second word as errored; a stuff error ends the packet
	task automatic rx_packet(input logic [15:0] w [2], input logic bad);
		line_state = utmi_sie_pkg::LINE_K;
		for (int i = 0; i < 2; i++) begin
			repeat (3) @(posedge core_clk);
			#1 receive_active = 1'b1;
			data_in = w[i];
			receive_valid = 1'b1;
			receive_error = bad && (i == 1);
			@(posedge core_clk);
			#1 receive_valid = 1'b0;
			data_in = ~w[i];
			if (receive_error) receive_active = 1'b0;
			receive_error = 1'b0;
		end
		repeat (3) @(posedge core_clk);
		#1 receive_active = 1'b0;
		line_state = utmi_sie_pkg::LINE_J;
	endtask
endmodule

// ==== dv/utmi_sie_tb_top.sv ====
module utmi_sie_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        core_clk = 0, reset = 1, slow = 0, tx_in_valid = 0, tx_in_last = 0;
	logic        rx_out_ready = 0, tx_in_ready, rx_out_valid, rx_out_last, rx_out_error;
	logic        transmit_valid, transmit_ready, data_oe, receive_active, receive_valid;
	logic        receive_error, operating_mode_select_hi, operating_mode_select_lo;
	logic [15:0] tx_in_data = 0, rx_out_data, data_out, data_in;
	logic [1:0]  mode_request = 0, line_state;
	int          n_errors = 0, comparisons = 0, cycles = 0, idle_run = 0, last_gap = 0;
	utmi_sie uut (.core_clk, .reset, .tx_in_valid, .tx_in_ready, .tx_in_data, .tx_in_last,
		.rx_out_valid, .rx_out_ready, .rx_out_data, .rx_out_last, .rx_out_error,
		.mode_request, .transmit_valid, .transmit_ready, .data_out, .data_oe, .data_in,
		.receive_active, .receive_valid, .receive_error, .line_state,
		.operating_mode_select_hi, .operating_mode_select_lo);
	utmi_xcvr_model model (.core_clk, .reset, .transmit_valid, .transmit_ready, .data_out,
		.data_in, .receive_active, .receive_valid, .receive_error, .line_state, .slow);
	always #2.5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		if (transmit_valid === 1'b1 && idle_run != 0) last_gap = idle_run;
		idle_run = (transmit_valid === 1'b1) ? 0 : idle_run + 1;
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			summarize();
		end
	end
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic send(input int n, input logic [15:0] base);
		logic ok;
		for (int i = 0; i < n; i++) begin
			tx_in_valid = 1'b1;
			tx_in_data = base + 16'(i);
			tx_in_last = (i == n - 1);
			do begin
				@(negedge core_clk);
				ok = tx_in_ready;
				@(posedge core_clk);
				#1;
			end while (ok !== 1'b1);
		end
		tx_in_valid = 1'b0;
		tx_in_last = 1'b0;
	endtask
	task automatic settle(input int n);
		for (int i = 0; i < 200; i++) begin
			if (model.tx_log.size() == n && transmit_valid === 1'b0) break;
			@(posedge core_clk);
			#1;
		end
	endtask
	task automatic t_mode();
		logic [15:0] want;
		for (int m = 0; m < 4; m++) begin
			mode_request = 2'(m);
			// the reserved code leaves the previous mode in place
			want = (m == 3) ? 16'h0002 : 16'(m);
			repeat (3) @(posedge core_clk);
			#1;
			check({operating_mode_select_hi, operating_mode_select_lo}, want);
		end
		mode_request = utmi_sie_pkg::OPMODE_NORMAL;
		repeat (3) @(posedge core_clk);
		#1 $display("mode test done");
	endtask
	task automatic t_tx(input logic s);
		slow = s;
		model.tx_log.delete();
		send(4, 16'h00c3);
		// the last word is taken while the packet is still on the pins
		check(data_oe, 1'b1);
		settle(4);
		for (int i = 0; i < 4; i++) check(model.tx_log[i], 16'h00c3 + 16'(i));
		check(model.hold_bad, 1'b0);
		check(transmit_valid, 1'b0);
		check(data_oe, 1'b0);
		$display("tx test done");
	endtask
	task automatic t_gap();
		model.tx_log.delete();
		send(1, 16'h0069);
		@(posedge core_clk);
		#1;
		send(1, 16'h00e1);
		settle(2);
		check(model.tx_log[0], 16'h0069);
		check(model.tx_log[1], 16'h00e1);
		check(last_gap >= utmi_sie_pkg::IPG_CYCLES, 1'b1);
		$display("gap test done");
	endtask
	task automatic t_busy();
		int bad;
		bad = 0;
		model.line_state = utmi_sie_pkg::LINE_K;
		model.tx_log.delete();
		send(1, 16'h002d);
		repeat (20) begin
			@(posedge core_clk);
			#1;
			if (transmit_valid !== 1'b0) bad++;
		end
		check(16'(bad), 16'h0000);
		// non-driving mode must hold the word back on an idle bus as well
		mode_request = utmi_sie_pkg::OPMODE_NODRIVE;
		model.line_state = utmi_sie_pkg::LINE_J;
		repeat (20) begin
			@(posedge core_clk);
			#1;
			if (transmit_valid !== 1'b0) bad++;
		end
		check(16'(bad), 16'h0000);
		mode_request = utmi_sie_pkg::OPMODE_NORMAL;
		settle(1);
		check(model.tx_log[0], 16'h002d);
		$display("busy test done");
	endtask
	task automatic t_rx(input logic bad);
		logic [15:0] exp [3];
		logic [15:0] d;
		logic        got, l, e;
		int          n;
		exp[0] = 16'h00a5;
		// an errored word is dropped and the end marker carries the flag
		exp[1] = bad ? 16'h0000 : 16'h1234;
		exp[2] = 16'h0000;
		n = bad ? 2 : 3;
		// a packet arriving in the gap after sending would be ignored
		repeat (utmi_sie_pkg::IPG_CYCLES + 4) @(posedge core_clk);
		#1;
		fork
			model.rx_packet('{16'h00a5, 16'h1234}, bad);
			for (int k = 0; k < n; k++) begin
				repeat (4) @(posedge core_clk);
				#1 rx_out_ready = 1'b1;
				for (int t = 0; t < 100; t++) begin
					@(negedge core_clk);
					{got, e, l, d} = {rx_out_valid, rx_out_error, rx_out_last, rx_out_data};
					@(posedge core_clk);
					#1;
					if (got === 1'b1) break;
				end
				rx_out_ready = 1'b0;
				check(d, exp[k]);
				check(l, k == n - 1);
				check(e, bad && (k == n - 1));
			end
		join
		$display("rx test done");
	endtask
	task automatic summarize();
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge core_clk);
		#1 reset = 1'b0;
		check(transmit_valid, 1'b0);
		t_mode();
		t_tx(1'b0);
		t_tx(1'b1);
		t_gap();
		t_busy();
		t_rx(1'b0);
		t_rx(1'b1);
		summarize();
	end
endmodule
